// File: logic/ptm_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - 10-bit counter counts selected clock when running
// - Comparators A and P match against counter
// - Enable rise clears count; fall holds count
// - Pause holds count, resume continues from it
// - Clock select chooses system, divided, sub or pin edge
// - Reserved clock code gives no count
// - Mode field selects one of four modes
// - Compare mode: A match drives, clears, toggles
// - PWM mode: inactive, active, PWM, single pulse
// - Capture mode: edge choice or disabled
// - Requested level equal to initial: no change
// - Enable rise restores initial pin level
// - Initial level bit: start level or polarity
// - Invert bit inverts both output pins, except in timer mode where both pins are held low
// - Capture source: pin 0 input or external clock pin
// - Clear select chooses A or P match clear
// - P zero with select low: overflow clears
// - Clear select ignored in PWM, pulse, capture
// - Automatic clears raise an interrupt indication
// - Clear on A suppresses the P flag
// - A zero: run to overflow, no A flag
// - P matches never change compare-mode pins; in PWM single pulse a P match ends the pulse
module ptm_timer
  import ptm_pkg::*;
#(
  parameter int count_width = 10
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and pins
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic external_clock_input,
  input wire logic pin0_in,
  input wire logic pin1_in,
  output logic output_pin_0,
  output logic output_pin_1,
  output logic output_pin_oe,
  // Event flags
  output logic compare_a_flag,
  output logic compare_p_flag,
  output logic timer_event
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ptm_regs_type regs;
    logic [count_width-1:0] count;
    logic [5:0] div_sys;
    logic [5:0] div_h;
    logic ext_prev;
    logic cap_prev;
    logic on_prev;
    logic level;
    logic pulse_done;
    logic flag_a;
    logic flag_p;
    logic sticky_a;
    logic sticky_p;
    logic evt;
    ptm_pins_type pins;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ptm_state_type;

  ptm_state_type state_q;
  ptm_state_type state_d;

  function automatic logic [9:0] ptm_merge_hi(input logic [9:0] cur, input logic [1:0] hi);
    ptm_merge_hi = {hi, cur[7:0]};
  endfunction : ptm_merge_hi

  function automatic logic [9:0] ptm_merge_lo(input logic [9:0] cur, input logic [7:0] lo);
    ptm_merge_lo = {cur[9:8], lo};
  endfunction : ptm_merge_lo

  logic on_bit;
  logic pause_bit;
  ptm_clksel_type cksel;
  ptm_mode_type mode;
  logic [1:0] iofn;
  logic init_lvl;
  logic invert;
  logic tick;
  logic on_rise;
  logic match_a;
  logic match_p;
  logic cap_sig;
  logic cap_edge;
  logic pwm_wave;
  logic active_out;
  logic drive;
  logic setup_ok;
  logic [count_width-1:0] cmp_a_w;
  logic [count_width-1:0] cmp_p_w;

  always_comb
  begin
    state_d = state_q;
    on_bit = state_q.regs.run_ctrl[ptm_bit_on];
    pause_bit = state_q.regs.run_ctrl[ptm_bit_pause];
    cksel = ptm_clksel_type'(state_q.regs.run_ctrl[ptm_bit_ck_lo +: 3]);
    mode = ptm_mode_type'(state_q.regs.mode_ctrl[ptm_bit_mode_lo +: 2]);
    iofn = state_q.regs.mode_ctrl[ptm_bit_io_lo +: 2];
    init_lvl = state_q.regs.mode_ctrl[ptm_bit_init];
    invert = state_q.regs.mode_ctrl[ptm_bit_invert];
    cmp_a_w = state_q.regs.cmp_a[count_width-1:0];
    cmp_p_w = state_q.regs.cmp_p[count_width-1:0];
    on_rise = on_bit && !state_q.on_prev;
    state_d.on_prev = on_bit;
    state_d.ext_prev = external_clock_input;

    // ----------------------------------------
    // Count clock selection
    // ----------------------------------------
    state_d.div_sys = (state_q.div_sys == 6'(ptm_div_sys4 - 1)) ? 6'h00 : state_q.div_sys + 6'h01;
    if (high_clock_tick)
    begin
      state_d.div_h = state_q.div_h + 6'h01;
    end
    case (cksel)
      ptm_ck_sys4: tick = (state_q.div_sys == 6'h00);
      ptm_ck_sys: tick = 1'b1;
      ptm_ck_h16: tick = high_clock_tick && (state_q.div_h[3:0] == 4'h0);
      ptm_ck_h64: tick = high_clock_tick && (state_q.div_h == 6'h00);
      ptm_ck_sub: tick = sub_clock_tick;
      ptm_ck_ext_rise: tick = external_clock_input && !state_q.ext_prev;
      ptm_ck_ext_fall: tick = !external_clock_input && state_q.ext_prev;
      default: tick = 1'b0;
    endcase

    // ----------------------------------------
    // Comparators and counter
    // ----------------------------------------
    match_a = (state_q.count == cmp_a_w) && (cmp_a_w != '0);
    match_p = (state_q.count == cmp_p_w);
    state_d.flag_a = 1'b0;
    state_d.flag_p = 1'b0;
    state_d.evt = 1'b0;
    cap_edge = 1'b0;
    setup_ok = 1'b0;

    if (on_rise)
    begin
      state_d.count = '0;
      state_d.level = init_lvl;
      state_d.pulse_done = 1'b0;
    end
    else if (on_bit && !pause_bit && tick)
    begin
      state_d.count = state_q.count + 1'b1;
      if (mode == ptm_mode_compare || mode == ptm_mode_timer)
      begin
        state_d.flag_a = match_a;
        if (state_q.regs.mode_ctrl[ptm_bit_clrsel])
        begin
          if (match_a)
          begin
            state_d.count = '0;
            state_d.evt = 1'b1;
          end
          else if (state_q.count == count_width'(ptm_count_max))
          begin
            state_d.evt = 1'b1;
          end
        end
        else
        begin
          state_d.flag_p = match_p && (cmp_p_w != '0);
          if (match_p && cmp_p_w != '0)
          begin
            state_d.count = '0;
            state_d.evt = 1'b1;
          end
          else if (state_q.count == count_width'(ptm_count_max))
          begin
            state_d.evt = 1'b1;
          end
        end
        if (mode == ptm_mode_compare && match_a)
        begin
          case (iofn)
            2'h1: state_d.level = 1'b0;
            2'h2: state_d.level = 1'b1;
            2'h3: state_d.level = !state_q.level;
            default: state_d.level = state_q.level;
          endcase
          if (iofn != 2'h3 && state_d.level == init_lvl)
          begin
            state_d.level = state_q.level;
          end
        end
      end
      else if (mode == ptm_mode_pwm)
      begin
        state_d.flag_a = match_a;
        state_d.flag_p = match_p && (cmp_p_w != '0);
        if (match_p && cmp_p_w != '0)
        begin
          state_d.count = '0;
          state_d.evt = 1'b1;
          if (iofn == 2'h3)
          begin
            state_d.pulse_done = 1'b1;
          end
        end
        else if (state_q.count == count_width'(ptm_count_max))
        begin
          state_d.evt = 1'b1;
        end
      end
      else
      begin
        // Capture mode counts freely and wraps at full scale
        state_d.evt = (state_q.count == count_width'(ptm_count_max));
      end
    end

    // ----------------------------------------
    // Capture
    // ----------------------------------------
    cap_sig = state_q.regs.mode_ctrl[ptm_bit_capsrc] ? external_clock_input : pin0_in;
    state_d.cap_prev = cap_sig;
    case (iofn)
      2'h0: cap_edge = cap_sig && !state_q.cap_prev;
      2'h1: cap_edge = !cap_sig && state_q.cap_prev;
      2'h2: cap_edge = cap_sig != state_q.cap_prev;
      default: cap_edge = 1'b0;
    endcase
    if (mode == ptm_mode_capture && on_bit && cap_edge)
    begin
      state_d.regs.cmp_a = 10'(state_q.count);
      state_d.flag_a = 1'b1;
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    pwm_wave = (state_q.count < cmp_a_w);
    case (iofn)
      2'h0: active_out = 1'b0;
      2'h1: active_out = 1'b1;
      2'h2: active_out = on_bit && pwm_wave;
      default: active_out = on_bit && !state_q.pulse_done && pwm_wave;
    endcase
    drive = (mode == ptm_mode_pwm) ? (init_lvl ? active_out : !active_out) : state_q.level;
    state_d.pins.pin0 = drive ^ invert;
    state_d.pins.pin1 = drive ^ invert;
    state_d.pins.pin_oe = (mode == ptm_mode_compare) || (mode == ptm_mode_pwm);
    if (mode == ptm_mode_timer)
    begin
      state_d.pins.pin0 = 1'b0;
      state_d.pins.pin1 = 1'b0;
    end

    // ----------------------------------------
    // Sticky status, set wins over clear
    // ----------------------------------------
    state_d.ready = 1'b0;
    state_d.err = 1'b0;
    setup_ok = psel && !penable;
    if (setup_ok && pwrite && paddr == ptm_off_status)
    begin
      state_d.sticky_a = state_q.sticky_a && !pwdata[0];
      state_d.sticky_p = state_q.sticky_p && !pwdata[1];
    end
    if (state_d.flag_a)
    begin
      state_d.sticky_a = 1'b1;
    end
    if (state_d.flag_p)
    begin
      state_d.sticky_p = 1'b1;
    end

    // ----------------------------------------
    // APB access, answered one cycle after setup
    // ----------------------------------------
    if (setup_ok)
    begin
      state_d.ready = 1'b1;
      state_d.rdata = 32'h0000_0000;
      case (paddr)
        ptm_off_run_ctrl:
        begin
          state_d.rdata = {24'h000000, state_q.regs.run_ctrl};
          if (pwrite)
            state_d.regs.run_ctrl = {pwdata[7:3], 3'h0};
        end
        ptm_off_mode_ctrl:
        begin
          state_d.rdata = {24'h000000, state_q.regs.mode_ctrl};
          if (pwrite)
            state_d.regs.mode_ctrl = pwdata[7:0];
        end
        ptm_off_count_lo: state_d.rdata = {24'h000000, 8'(state_q.count)};
        ptm_off_count_hi: state_d.rdata = {30'h0, 2'(state_q.count >> 8)};
        ptm_off_cmpa_lo:
        begin
          state_d.rdata = {24'h000000, state_q.regs.cmp_a[7:0]};
          if (pwrite)
            state_d.regs.cmp_a = ptm_merge_lo(state_q.regs.cmp_a, pwdata[7:0]);
        end
        ptm_off_cmpa_hi:
        begin
          state_d.rdata = {30'h0, state_q.regs.cmp_a[9:8]};
          if (pwrite)
            state_d.regs.cmp_a = ptm_merge_hi(state_q.regs.cmp_a, pwdata[1:0]);
        end
        ptm_off_cmpp_lo:
        begin
          state_d.rdata = {24'h000000, state_q.regs.cmp_p[7:0]};
          if (pwrite)
            state_d.regs.cmp_p = ptm_merge_lo(state_q.regs.cmp_p, pwdata[7:0]);
        end
        ptm_off_cmpp_hi:
        begin
          state_d.rdata = {30'h0, state_q.regs.cmp_p[9:8]};
          if (pwrite)
            state_d.regs.cmp_p = ptm_merge_hi(state_q.regs.cmp_p, pwdata[1:0]);
        end
        ptm_off_status: state_d.rdata = {30'h0, state_q.sticky_p, state_q.sticky_a};
        default: state_d.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;
  assign output_pin_0 = state_q.pins.pin0;
  assign output_pin_1 = state_q.pins.pin1;
  assign output_pin_oe = state_q.pins.pin_oe;
  assign compare_a_flag = state_q.flag_a;
  assign compare_p_flag = state_q.flag_p;
  assign timer_event = state_q.evt;

endmodule : ptm_timer

// File: logic/ptm_pkg.sv
package ptm_pkg;

  // ----------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------
  localparam logic [7:0] ptm_off_run_ctrl = 8'h00;
  localparam logic [7:0] ptm_off_mode_ctrl = 8'h04;
  localparam logic [7:0] ptm_off_count_lo = 8'h08;
  localparam logic [7:0] ptm_off_count_hi = 8'h0c;
  localparam logic [7:0] ptm_off_cmpa_lo = 8'h10;
  localparam logic [7:0] ptm_off_cmpa_hi = 8'h14;
  localparam logic [7:0] ptm_off_cmpp_lo = 8'h18;
  localparam logic [7:0] ptm_off_cmpp_hi = 8'h1c;
  localparam logic [7:0] ptm_off_status = 8'h20;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ptm_bit_pause = 7;
  localparam int ptm_bit_ck_lo = 4;
  localparam int ptm_bit_on = 3;
  localparam int ptm_bit_mode_lo = 6;
  localparam int ptm_bit_io_lo = 4;
  localparam int ptm_bit_init = 3;
  localparam int ptm_bit_invert = 2;
  localparam int ptm_bit_capsrc = 1;
  localparam int ptm_bit_clrsel = 0;
  localparam logic [7:0] ptm_ctrl_reset = 8'h00;
  localparam logic [9:0] ptm_count_max = 10'h3ff;
  localparam int ptm_div_sys4 = 4;
  localparam int ptm_div_h16 = 16;
  localparam int ptm_div_h64 = 64;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    ptm_mode_compare = 2'h0,
    ptm_mode_capture = 2'h1,
    ptm_mode_pwm = 2'h2,
    ptm_mode_timer = 2'h3
  } ptm_mode_type;

  typedef enum logic [2:0] {
    ptm_ck_sys4 = 3'h0,
    ptm_ck_sys = 3'h1,
    ptm_ck_h16 = 3'h2,
    ptm_ck_h64 = 3'h3,
    ptm_ck_sub = 3'h4,
    ptm_ck_reserved = 3'h5,
    ptm_ck_ext_rise = 3'h6,
    ptm_ck_ext_fall = 3'h7
  } ptm_clksel_type;

  typedef struct packed {
    logic [7:0] run_ctrl;
    logic [7:0] mode_ctrl;
    logic [9:0] cmp_a;
    logic [9:0] cmp_p;
  } ptm_regs_type;

  typedef struct packed {
    logic pin0;
    logic pin1;
    logic pin_oe;
  } ptm_pins_type;

endpackage : ptm_pkg

// File: test/ptm_properties.sv
`timescale 1ns/1ps
module ptm_checker
  import ptm_pkg::*;
#(
  parameter int count_width = 10
) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer
  input wire logic output_pin_0,
  input wire logic output_pin_1,
  input wire logic compare_a_flag,
  input wire logic compare_p_flag,
  input wire logic timer_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Bus answer
  // ----
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  AST_READY_NEXT: assert property (s_setup |=> s_answer)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // ----
  // Timer events
  // ----
  AST_A_PULSE: assert property (compare_a_flag |=> !compare_a_flag)
    else $error("a flag too long");
  AST_P_PULSE: assert property (compare_p_flag |=> !compare_p_flag)
    else $error("p flag too long");
  AST_EVENT_PULSE: assert property (timer_event |=> !timer_event)
    else $error("event too long");
  AST_PINS_ALIKE: assert property (output_pin_0 == output_pin_1)
    else $error("pins differ");
endmodule : ptm_checker

bind ptm_timer ptm_checker #(.count_width(count_width)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_pin_0(output_pin_0), .output_pin_1(output_pin_1), .compare_a_flag(compare_a_flag),
  .compare_p_flag(compare_p_flag), .timer_event(timer_event));

// File: test/ptm_pin_model.sv
`timescale 1ns/1ps
module ptm_pin_model (
  // Control
  input wire logic pclk,
  input wire logic run,
  // Pins
  input wire logic pin0_out,
  input wire logic pin1_out,
  input wire logic pin_oe,
  output logic ext_clk,
  output logic pin0_in,
  output logic pin1_in
);
  int n = 0;
  initial ext_clk = 1'b0;
  // ----
  // Far side
  // ----
  // Stands still when idle, so no stray capture edge between scenarios
  always @(posedge pclk)
  begin
    n <= run ? n + 1 : 0;
    if (run && n % 8 == 7)
      ext_clk <= ~ext_clk;
  end
  // Pull-up on released pins
  assign pin0_in = pin_oe ? pin0_out : 1'b1;
  assign pin1_in = pin_oe ? pin1_out : 1'b1;
endmodule : ptm_pin_model

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ptm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, hk = 1'b0, sk = 1'b0, run = 1'b0;
  logic ext, p0i, p1i, po0, po1, poe, fa, fp, ev;
  int miscompares = 0, checks = 0, na, np, ne;
  always #5 pclk = ~pclk;
  always @(posedge pclk) hk <= ~hk;
  always @(posedge pclk) sk <= hk & ~sk;
  ptm_timer #(.count_width(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_clock_tick(hk), .sub_clock_tick(sk), .external_clock_input(ext), .pin0_in(p0i), .pin1_in(p1i),
    .output_pin_0(po0), .output_pin_1(po1), .output_pin_oe(poe), .compare_a_flag(fa),
    .compare_p_flag(fp), .timer_event(ev));
  ptm_pin_model pm_u (.pclk(pclk), .run(run), .pin0_out(po0), .pin1_out(po1), .pin_oe(poe),
    .ext_clk(ext), .pin0_in(p0i), .pin1_in(p1i));
  // ----
  // Helpers
  // ----
  task report_and_stop;
    begin
      if (miscompares == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : report_and_stop
  task ck(input logic [31:0] g, input logic [31:0] x);
    begin
      checks++;
      if (g !== x)
      begin
        miscompares++;
        $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask : ck
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
        @(posedge pclk);
        if (pready === 1'b1) break;
      end
      if (i == 50)
      begin
        miscompares++;
        report_and_stop();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let an idle edge pass so the next call never re-drives psel in the same step
      @(posedge pclk);
    end
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task cnt(input int n);
    begin
      na = 0;
      np = 0;
      ne = 0;
      repeat (n)
      begin
        @(posedge pclk);
        na += int'(fa === 1'b1);
        np += int'(fp === 1'b1);
        ne += int'(ev === 1'b1);
      end
    end
  endtask : cnt
  // Always stops the timer first, since changes while running are unreliable
  task cfg(input logic [7:0] m, input logic [9:0] a, input logic [9:0] p, input logic [2:0] c);
    begin
      wr(ptm_off_run_ctrl, 32'h0);
      wr(ptm_off_mode_ctrl, {24'h0, m});
      wr(ptm_off_cmpa_lo, {24'h0, a[7:0]});
      wr(ptm_off_cmpa_hi, {30'h0, a[9:8]});
      wr(ptm_off_cmpp_lo, {24'h0, p[7:0]});
      wr(ptm_off_cmpp_hi, {30'h0, p[9:8]});
      wr(ptm_off_run_ctrl, {25'h0, c, 4'h8});
    end
  endtask : cfg
  // ----
  // Scenarios
  // ----
  task t_regs;
    begin
      rd(ptm_off_run_ctrl);
      ck(q, 32'h0);
      rd(ptm_off_mode_ctrl);
      ck(q, 32'h0);
      wr(ptm_off_count_lo, 32'h55);
      rd(ptm_off_count_lo);
      ck(q, 32'h0);
      rd(8'h24);
      ck({q[30:0], e}, 32'h1);
      wr(ptm_off_cmpa_hi, 32'hff);
      rd(ptm_off_cmpa_hi);
      ck(q, 32'h3);
    end
  endtask : t_regs
  task t_count;
    logic [31:0] c1;
    logic [2:0] cs [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};
    int lo [5] = '{32, 4, 1, 65, 8};
    begin
      cfg(8'hc0, 10'h0, 10'h0, 3'h1);
      rd(ptm_off_count_lo);
      c1 = q;
      rd(ptm_off_count_lo);
      ck(q - c1, 32'd3);
      wr(ptm_off_run_ctrl, 32'h98);
      rd(ptm_off_count_lo);
      c1 = q;
      rd(ptm_off_count_lo);
      ck(q - c1, 32'd0);
      wr(ptm_off_run_ctrl, 32'h18);
      rd(ptm_off_count_lo);
      ck(32'(q - c1 - 32'd1 < 32'd4), 32'd1);
      wr(ptm_off_run_ctrl, 32'h10);
      rd(ptm_off_count_lo);
      c1 = q;
      rd(ptm_off_count_lo);
      ck(q - c1, 32'd0);
      wr(ptm_off_run_ctrl, 32'h18);
      rd(ptm_off_count_lo);
      ck(32'(q < 32'd4), 32'd1);
      wr(ptm_off_run_ctrl, 32'h50);
      wr(ptm_off_run_ctrl, 32'h58);
      rd(ptm_off_count_lo);
      ck(q, 32'd0);
      wr(ptm_off_run_ctrl, 32'h60);
      run <= 1'b1;
      wr(ptm_off_run_ctrl, 32'h68);
      rd(ptm_off_count_lo);
      c1 = q;
      repeat (32) @(posedge pclk);
      rd(ptm_off_count_lo);
      ck(32'(q - c1 - 32'd1 < 32'd3), 32'd1);
      run <= 1'b0;
      // Divided, sub and falling pin clocks over a 131-cycle window
      for (int k = 0; k < 5; k++)
      begin
        cfg(8'hc0, 10'h0, 10'h0, cs[k]);
        run <= 1'b1;
        rd(ptm_off_count_lo);
        c1 = q;
        repeat (128) @(posedge pclk);
        rd(ptm_off_count_lo);
        run <= 1'b0;
        ck(32'(q - c1 >= lo[k] && q - c1 <= lo[k] + 1), 32'd1);
      end
    end
  endtask : t_count
  task t_clear;
    begin
      cfg(8'hc0, 10'h3, 10'h5, 3'h1);
      cnt(60);
      ck(32'(np >= 9 && np <= 11), 32'd1);
      ck(32'(na == np && ne == np), 32'd1);
      cfg(8'hc1, 10'h7, 10'h3, 3'h1);
      cnt(64);
      ck(np, 32'd0);
      ck(32'(na >= 7 && na <= 9), 32'd1);
      cfg(8'hc0, 10'h0, 10'h0, 3'h1);
      cnt(1100);
      ck(na, 32'd0);
      ck(ne, 32'd1);
    end
  endtask : t_clear
  task t_pins;
    logic [7:0] m [8] = '{8'h31, 8'h39, 8'h35, 8'h11, 8'h21, 8'h01, 8'h98, 8'h88};
    logic [1:0] x [8] = '{2'b01, 2'b10, 2'b10, 2'b00, 2'b01, 2'b00, 2'b11, 2'b00};
    int i;
    begin
      for (int k = 0; k < 8; k++)
      begin
        cfg(m[k], 10'h9, 10'h0, 3'h1);
        // Restored level reaches the pin two edges after the enable write
        @(posedge pclk);
        ck({30'h0, poe, po0}, {30'h1, x[k][1]});
        for (i = 0; i < 40; i++)
        begin
          @(posedge pclk);
          if (fa === 1'b1) break;
        end
        ck(32'(i < 40), 32'd1);
        repeat (2) @(posedge pclk);
        ck({30'h0, po1, po0}, {30'h0, x[k][0], x[k][0]});
      end
    end
  endtask : t_pins
  task t_capture;
    logic [7:0] m [5] = '{8'h72, 8'h40, 8'h42, 8'h52, 8'h62};
    int x [5] = '{0, 0, 4, 4, 8};
    begin
      for (int k = 0; k < 5; k++)
      begin
        cfg(m[k], 10'h0, 10'h0, 3'h1);
        run <= 1'b1;
        cnt(64);
        run <= 1'b0;
        ck(32'(na >= x[k] - 1 && na <= x[k] + 1), 32'd1);
      end
      // Last setup captures on both edges, so A holds a running count
      rd(ptm_off_cmpa_lo);
      ck(32'(q != 32'h0), 32'd1);
    end
  endtask : t_capture
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_count();
    t_clear();
    t_pins();
    t_capture();
    report_and_stop();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
endmodule : tb_top
